/* File: src/rtt_pkg.sv */
package rtt_pkg;
   // register byte offsets, per timer block of 8
   localparam logic [4:0] RTT_OFF_CNT_HI = 5'h00;
   localparam logic [4:0] RTT_OFF_CNT_LO = 5'h01;
   localparam logic [4:0] RTT_OFF_RLD_HI = 5'h02;
   localparam logic [4:0] RTT_OFF_RLD_LO = 5'h03;
   localparam logic [4:0] RTT_OFF_CTRL = 5'h04;
   localparam logic [4:0] RTT_TIMER_STRIDE = 5'h08;
   // shared interrupt registers
   localparam logic [4:0] RTT_OFF_IRQ_STAT = 5'h10;
   localparam logic [4:0] RTT_OFF_IRQ_CLR = 5'h11;
   localparam logic [4:0] RTT_OFF_IRQ_EN = 5'h12;
   // control fields
   localparam int RTT_CTRL_EN_BIT = 7;
   localparam int RTT_CTRL_POL_BIT = 6;
   localparam int RTT_CTRL_PRE_LSB = 3;
   localparam int RTT_CTRL_OUTEN_BIT = 1;
   localparam int RTT_CTRL_MODE_BIT = 0;
   // reset values, restart count and number of timers
   localparam logic [15:0] RTT_CNT_RESET = 16'h0000;
   localparam logic [15:0] RTT_RLD_RESET = 16'h0000;
   localparam logic [7:0] RTT_CTRL_RESET = 8'h00;
   localparam logic [15:0] RTT_RESTART_CNT = 16'h0001;
   localparam int RTT_NUM_TIMERS = 2;
   typedef enum logic [0:0] {
      RTT_MODE_ONESHOT = 1'b0,
      RTT_MODE_CONT = 1'b1
   } rtt_mode_type;
endpackage : rtt_pkg

/* File: src/rtt_timer.sv */
// Operation
// - two independent 16-bit up-counting timers
// - prescaler divides by 1 to 128
// - reload 0001H, prescale 1: shortest timeout
// - reload 0000H acts as 65536-count span
// - counter wraps FFFFH to 0000H, keeps counting
// - one-shot: interrupt, count 0001H, self-disable
// - one-shot output inverts for one cycle
// - one-shot timeout (reload-start+1) times prescale
// - continuous: interrupt, load 0001H, keep running
// - continuous output toggles each reload
// - start count only affects first pass
// - continuous period reload times prescale
// - output starts at programmed polarity level
//
// Added by the designer: the register addresses and strobed register access.
`timescale 1ns/1ns
module rtt_timer (
   input wire logic clk_i,
   input wire logic rst_b_i,
   input wire logic [4:0] addr_i,
   input wire logic [7:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [7:0] rdata_o,
   output logic [1:0] tmr_out_o,
   output logic irq_o
);
   localparam int N = rtt_pkg::RTT_NUM_TIMERS;

   logic rst_meta_q;
   logic rst_sync_q;
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         rst_meta_q <= 1'b0;
         rst_sync_q <= 1'b0;
      end else begin
         rst_meta_q <= 1'b1;
         rst_sync_q <= rst_meta_q;
      end
   end
   wire rst_n = rst_sync_q;

   function automatic logic hit(input logic [4:0] a, input logic [4:0] off);
      hit = (a == off);
   endfunction : hit

   logic [N-1:0] event_w;
   logic [N-1:0] irq_stat_q;
   logic [N-1:0] irq_en_q;
   logic [7:0] rd_mux [N];
   logic [N-1:0] rd_hit;

   genvar g;
   generate
      for (g = 0; g < N; g++) begin : g_tmr
         localparam logic [4:0] BASE = 5'(g * 8);
         logic [15:0] cnt_q;
         logic [15:0] rld_q;
         logic [7:0] ctrl_q;
         logic [6:0] pre_q;
         logic out_q;
         logic pulse_q;
         logic [6:0] div_max;
         logic tick;
         logic at_rld;
         logic en;
         logic cont;
         logic pol;

         assign en = ctrl_q[rtt_pkg::RTT_CTRL_EN_BIT];
         assign pol = ctrl_q[rtt_pkg::RTT_CTRL_POL_BIT];
         assign cont = ctrl_q[rtt_pkg::RTT_CTRL_MODE_BIT] == rtt_pkg::RTT_MODE_CONT;
         assign div_max = 7'((8'h01 << ctrl_q[rtt_pkg::RTT_CTRL_PRE_LSB +: 3]) - 8'h01);
         assign tick = en && (pre_q == div_max);
         assign at_rld = (cnt_q == rld_q);

         always_ff @(posedge clk_i or negedge rst_n) begin
            if (!rst_n) begin
               pre_q <= 7'h00;
            end else if (!en || tick) begin
               pre_q <= 7'h00;
            end else begin
               pre_q <= pre_q + 7'h01;
            end
         end

         assign event_w[g] = tick && at_rld;

         always_ff @(posedge clk_i or negedge rst_n) begin
            if (!rst_n) begin
               cnt_q <= rtt_pkg::RTT_CNT_RESET;
            end else if (!en && wr_i && hit(addr_i, BASE + rtt_pkg::RTT_OFF_CNT_HI)) begin
               cnt_q[15:8] <= wdata_i;
            end else if (!en && wr_i && hit(addr_i, BASE + rtt_pkg::RTT_OFF_CNT_LO)) begin
               cnt_q[7:0] <= wdata_i;
            end else if (tick) begin
               if (at_rld) begin
                  cnt_q <= rtt_pkg::RTT_RESTART_CNT;
               end else begin
                  cnt_q <= cnt_q + 16'h0001;
               end
            end
         end

         always_ff @(posedge clk_i or negedge rst_n) begin
            if (!rst_n) begin
               rld_q <= rtt_pkg::RTT_RLD_RESET;
            end else if (wr_i && hit(addr_i, BASE + rtt_pkg::RTT_OFF_RLD_HI)) begin
               rld_q[15:8] <= wdata_i;
            end else if (wr_i && hit(addr_i, BASE + rtt_pkg::RTT_OFF_RLD_LO)) begin
               rld_q[7:0] <= wdata_i;
            end
         end

         always_ff @(posedge clk_i or negedge rst_n) begin
            if (!rst_n) begin
               ctrl_q <= rtt_pkg::RTT_CTRL_RESET;
            end else if (wr_i && hit(addr_i, BASE + rtt_pkg::RTT_OFF_CTRL)) begin
               ctrl_q <= wdata_i;
            end else if (event_w[g] && !cont) begin
               ctrl_q[rtt_pkg::RTT_CTRL_EN_BIT] <= 1'b0;
            end
         end

         always_ff @(posedge clk_i or negedge rst_n) begin
            if (!rst_n) begin
               out_q <= 1'b0;
               pulse_q <= 1'b0;
            end else if (!en) begin
               out_q <= pol;
               pulse_q <= 1'b0;
            end else if (cont) begin
               pulse_q <= 1'b0;
               if (event_w[g]) begin
                  out_q <= ~out_q;
               end
            end else begin
               pulse_q <= event_w[g];
               out_q <= event_w[g] ? ~pol : pol;
            end
         end

         // per-timer flop, one driver per output bit
         logic pin_q;
         logic [7:0] rmux;
         logic rhit;
         always_ff @(posedge clk_i or negedge rst_n) begin
            if (!rst_n) begin
               pin_q <= 1'b0;
            end else begin
               pin_q <= ctrl_q[rtt_pkg::RTT_CTRL_OUTEN_BIT] ? out_q : 1'b0;
            end
         end
         assign tmr_out_o[g] = pin_q;

         always_comb begin
            rhit = 1'b1;
            rmux = 8'h00;
            if (hit(addr_i, BASE + rtt_pkg::RTT_OFF_CNT_HI)) begin
               rmux = cnt_q[15:8];
            end else if (hit(addr_i, BASE + rtt_pkg::RTT_OFF_CNT_LO)) begin
               rmux = cnt_q[7:0];
            end else if (hit(addr_i, BASE + rtt_pkg::RTT_OFF_RLD_HI)) begin
               rmux = rld_q[15:8];
            end else if (hit(addr_i, BASE + rtt_pkg::RTT_OFF_RLD_LO)) begin
               rmux = rld_q[7:0];
            end else if (hit(addr_i, BASE + rtt_pkg::RTT_OFF_CTRL)) begin
               rmux = ctrl_q;
            end else begin
               rhit = 1'b0;
            end
         end
         assign rd_hit[g] = rhit;
         assign rd_mux[g] = rmux;
      end
   endgenerate

   // set wins over software clear
   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         irq_stat_q <= '0;
      end else if (wr_i && hit(addr_i, rtt_pkg::RTT_OFF_IRQ_CLR)) begin
         irq_stat_q <= (irq_stat_q & ~wdata_i[N-1:0]) | event_w;
      end else begin
         irq_stat_q <= irq_stat_q | event_w;
      end
   end

   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         irq_en_q <= '0;
      end else if (wr_i && hit(addr_i, rtt_pkg::RTT_OFF_IRQ_EN)) begin
         irq_en_q <= wdata_i[N-1:0];
      end
   end

   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         irq_o <= 1'b0;
      end else begin
         irq_o <= |(((irq_stat_q | event_w) & ~((wr_i && hit(addr_i, rtt_pkg::RTT_OFF_IRQ_CLR))
                  ? wdata_i[N-1:0] & ~event_w : '0)) & irq_en_q);
      end
   end

   // unmapped addresses read zero
   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         rdata_o <= 8'h00;
      end else if (rd_i) begin
         if (rd_hit[0]) begin
            rdata_o <= rd_mux[0];
         end else if (rd_hit[1]) begin
            rdata_o <= rd_mux[1];
         end else if (hit(addr_i, rtt_pkg::RTT_OFF_IRQ_STAT)) begin
            rdata_o <= {6'h00, irq_stat_q};
         end else if (hit(addr_i, rtt_pkg::RTT_OFF_IRQ_EN)) begin
            rdata_o <= {6'h00, irq_en_q};
         end else begin
            rdata_o <= 8'h00;
         end
      end else begin
         rdata_o <= 8'h00;
      end
   end
endmodule : rtt_timer

/* File: verif/rtt_timer_properties.sv */
`timescale 1ns/1ns
module rtt_chk (
   input wire logic clk_i,
   input wire logic rst_b_i,
   input wire logic [4:0] addr_i,
   input wire logic [7:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   input wire logic [7:0] rdata_o,
   input wire logic [1:0] tmr_out_o,
   input wire logic irq_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (!rst_b_i);
   AST_RD_IDLE: assert property (!rd_i |=> rdata_o == 8'h00)
      else $error("read data outside slot");
   AST_UNMAPPED: assert property (rd_i && addr_i > 5'h12 |=> rdata_o == 8'h00)
      else $error("unmapped read not zero");
   AST_CLR_WO: assert property (rd_i && addr_i == 5'h11 |=> rdata_o == 8'h00)
      else $error("clear register readable");
   AST_STAT_W: assert property (rd_i && addr_i == 5'h10 |=> rdata_o[7:2] == 6'h00)
      else $error("status spare bits set");
   AST_IRQ_MASK: assert property (wr_i && addr_i == 5'h12 && wdata_i == 8'h00 ##1 !wr_i
      |-> ##1 !irq_o)
      else $error("irq with all masked");
   AST_IRQ_SRC: assert property (irq_o && rd_i && addr_i == 5'h10 && !$past(wr_i)
      |=> rdata_o[1:0] != 2'b00)
      else $error("irq without status");
   AST_OUT_OFF0: assert property (wr_i && addr_i == 5'h04 && !wdata_i[1] ##1 !wr_i
      |-> ##1 !tmr_out_o[0])
      else $error("pin 0 driven while off");
   AST_OUT_OFF1: assert property (wr_i && addr_i == 5'h0c && !wdata_i[1] ##1 !wr_i
      |-> ##1 !tmr_out_o[1])
      else $error("pin 1 driven while off");
   AST_RST_QUIET: assert property ($rose(rst_b_i) |-> (!irq_o && tmr_out_o == 2'b00)[*2])
      else $error("outputs active after reset");
endmodule : rtt_chk
bind rtt_timer rtt_chk u_chk (.clk_i, .rst_b_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
   .tmr_out_o, .irq_o);

/* File: verif/tb_top.sv */
`timescale 1ns/1ns
module tb_top;
   logic clk_i = 1'b0;
   logic rst_b_i = 1'b0;
   logic [4:0] addr_i = 5'h00;
   logic [7:0] wdata_i = 8'h00;
   logic wr_i = 1'b0;
   logic rd_i = 1'b0;
   logic [7:0] rdata_o;
   logic [1:0] tmr_out_o;
   logic irq_o;
   int fails = 0;
   int num_checks = 0;
   int cyc = 0;
   int pulses = 0;
   int t0;
   int p0;
   rtt_timer uut (.clk_i, .rst_b_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .tmr_out_o,
      .irq_o);
   always #5 clk_i = ~clk_i;
   // hang guard, tests need some 380 cycles
   always @(posedge clk_i) begin
      cyc <= cyc + 1;
      if (tmr_out_o[0] === 1'b1) pulses <= pulses + 1;
      if (cyc == 3000) begin
         fails++;
         end_of_test();
      end
   end
   task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
      num_checks++;
      if (g !== e) begin
         $display("[ERR] %s exp %h got %h", n, e, g);
         fails++;
      end
   endtask : chk
   task automatic wr(input logic [4:0] a, input logic [7:0] d);
      @(posedge clk_i);
      wr_i <= 1'b1;
      addr_i <= a;
      wdata_i <= d;
      @(posedge clk_i);
      wr_i <= 1'b0;
   endtask : wr
   task automatic rd(input string n, input logic [4:0] a, input logic [7:0] e);
      @(posedge clk_i);
      rd_i <= 1'b1;
      addr_i <= a;
      @(posedge clk_i);
      rd_i <= 1'b0;
      #1 chk(n, {8'h00, e}, {8'h00, rdata_o});
   endtask : rd
   // detection lags one edge, same for every edge
   task automatic tog();
      logic v;
      v = tmr_out_o[1];
      for (int i = 0; i < 100 && tmr_out_o[1] === v; i++) @(posedge clk_i);
   endtask : tog
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : end_of_test
   initial begin
      repeat (5) @(posedge clk_i);
      rst_b_i <= 1'b1;
      repeat (3) @(posedge clk_i);
      rd("cnt lo", 5'h01, 8'h00);
      wr(5'h0a, 8'h12);
      wr(5'h0b, 8'h34);
      rd("rld hi", 5'h0a, 8'h12);
      rd("rld lo", 5'h0b, 8'h34);
      rd("gap", 5'h15, 8'h00);
      $display("test regs done");
      wr(5'h04, 8'h00);
      wr(5'h00, 8'hff);
      wr(5'h01, 8'hff);
      wr(5'h02, 8'h00);
      wr(5'h03, 8'h00);
      wr(5'h12, 8'h03);
      wr(5'h04, 8'hba);
      t0 = cyc;
      p0 = pulses;
      // two ticks of 128: wrap to 0000H, then match
      for (int i = 0; i < 300 && irq_o !== 1'b1; i++) @(posedge clk_i);
      chk("os time", 16'h1, {15'h0, (cyc - t0) inside {[256:258]}});
      rd("os ctrl", 5'h04, 8'h3a);
      rd("os cnt hi", 5'h00, 8'h00);
      rd("os cnt lo", 5'h01, 8'h01);
      chk("os pulse", 16'h1, 16'(pulses - p0));
      repeat (20) @(posedge clk_i);
      rd("os hold", 5'h01, 8'h01);
      rd("os stat", 5'h10, 8'h01);
      wr(5'h11, 8'h01);
      rd("os clr", 5'h10, 8'h00);
      $display("test oneshot done");
      // pol 1, divide 2, pin on, continuous
      wr(5'h0c, 8'h4b);
      wr(5'h08, 8'h00);
      wr(5'h09, 8'h03);
      wr(5'h0a, 8'h00);
      wr(5'h0b, 8'h04);
      chk("idle lvl", 16'h1, {15'h0, tmr_out_o[1]});
      wr(5'h0c, 8'hcb);
      tog();
      tog();
      t0 = cyc;
      tog();
      chk("period", 16'd8, 16'(cyc - t0));
      t0 = cyc;
      tog();
      chk("period2", 16'd8, 16'(cyc - t0));
      chk("irq", 16'h1, {15'h0, irq_o});
      rd("c stat", 5'h10, 8'h02);
      wr(5'h12, 8'h00);
      repeat (2) @(posedge clk_i);
      chk("masked", 16'h0, {15'h0, irq_o});
      wr(5'h0c, 8'h0b);
      wr(5'h11, 8'h02);
      rd("c clr", 5'h10, 8'h00);
      $display("test continuous done");
      end_of_test();
   end
endmodule : tb_top
